//--- design/fcss_pkg.sv
package fcss_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL1  = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL2  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TRIM   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // control 1 fields
  localparam int unsigned CLK_SRC_LSB      = 6;
  localparam int unsigned REF_DIV_LSB      = 3;
  localparam int unsigned INT_REF_SEL_BIT  = 2;
  localparam int unsigned INT_CLK_EN_BIT   = 1;
  localparam int unsigned INT_STOP_EN_BIT  = 0;
  // control 2 fields
  localparam int unsigned BUS_DIV_LSB      = 6;
  localparam int unsigned FREQ_RANGE_BIT   = 5;
  localparam int unsigned HIGH_GAIN_BIT    = 4;
  localparam int unsigned LOW_POWER_BIT    = 3;
  localparam int unsigned EXT_OSC_SEL_BIT  = 2;
  localparam int unsigned EXT_CLK_EN_BIT   = 1;
  localparam int unsigned EXT_STOP_EN_BIT  = 0;
  // status / control fields
  localparam int unsigned DCO_RANGE_LSB    = 6;
  localparam int unsigned DCO_MAX_BIT      = 5;
  localparam int unsigned INT_REF_ST_BIT   = 4;
  localparam int unsigned CLK_ST_LSB       = 2;
  localparam int unsigned LOCK_BIT         = 1;
  localparam int unsigned FINE_TRIM_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] CTRL1_RST  = 8'h04;
  localparam logic [DATA_W-1:0] CTRL2_RST  = 8'h40;
  localparam logic [DATA_W-1:0] TRIM_RST   = 8'h80;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;

  localparam logic [1:0] CLK_SRC_LOOP = 2'h0;
  localparam logic [1:0] CLK_SRC_IREF = 2'h1;
  localparam logic [1:0] CLK_SRC_EREF = 2'h2;
  localparam logic [1:0] DCO_RANGE_LOW = 2'h0;

  localparam logic [11:0] FLL_FACTOR_STD = 12'h200;
  localparam logic [11:0] FLL_FACTOR_MAX = 12'h260;

  typedef enum logic [2:0] {
    MODE_ENG_INT,
    MODE_ENG_EXT,
    MODE_BYP_INT,
    MODE_BYP_INT_LP,
    MODE_BYP_EXT,
    MODE_BYP_EXT_LP,
    MODE_STOP
  } fcss_mode_t;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } fcss_bus_req_t;

  typedef struct packed {
    logic high_gain_select;
    logic freq_range;
    logic ext_ref_osc_select;
    logic ext_ref_clock_enable;
    logic ext_ref_stop_enable;
  } fcss_osc_ctrl_t;

endpackage

//--- design/fcss_top.sv
// Operation
// - loop multiplies reference by 512 or 608
// - range select writes never change frequency
// - two-bit bus divider gives 1,2,4,8
// - reset comes up in engaged-internal mode
// - debug clock is oscillator divided by two
// - seven operating modes are implemented
// - engaged internal: loop output, loop debug clock
// - loop reference internal or external selectable
// - system source: loop, internal or external
// - external reference divided before feeding loop
// - nine internal reference trim bits held
// - five control outputs to crystal oscillator
// - option bit raises factor for 32768 Hz
// - engaged external: loop output, loop debug clock
// - low-power bypass: loop off, no debug clock
// - stop: no clocks, references enabled if configured
// - bus divider resets to divide by two
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module fcss_top
  import fcss_pkg::*;
#(
  parameter int unsigned          ACC_W   = 16,
  parameter logic [ACC_W-1:0]     FW_RST  = 16'h0400,
  parameter int unsigned          GAIN_SH = 4
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // register port
  input  wire fcss_bus_req_t      bus_i,
  output logic [DATA_W-1:0]       rdata_o,
  // reference clocks and system state
  input  wire logic               int_ref_clk_i,
  input  wire logic               ext_ref_clk_i,
  input  wire logic               stop_req_i,
  input  wire logic               debug_active_i,
  // clock outputs
  output logic                    bus_tick_o,
  output logic                    debug_clk_o,
  output logic                    fll_locked_o,
  output fcss_mode_t              mode_o,
  // reference and oscillator control
  output logic                    int_ref_enable_o,
  output logic [8:0]              int_trim_o,
  output fcss_osc_ctrl_t          osc_ctrl_o
);

  localparam int unsigned SW = ACC_W + 2;
  localparam logic [ACC_W-1:0] FW_MAX = {ACC_W{1'b1}};

  function automatic logic [10:0] ref_div_ratio(input logic [2:0] sel, input logic range);
    logic [10:0] r;
    r = 11'h001 << sel;
    if (range)
    begin
      r = (sel > 3'h5) ? 11'h400 : (11'h020 << sel);
    end
    return r;
  endfunction

  function automatic logic [3:0] bus_div_ratio(input logic [1:0] sel);
    return 4'h1 << sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [DATA_W-1:0]  ctrl1_ff;
  logic [DATA_W-1:0]  ctrl2_ff;
  logic [DATA_W-1:0]  trim_ff;
  logic [DATA_W-1:0]  status_ff;
  fcss_mode_t         mode_ff;
  logic               locked_ff;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl1_ff  <= CTRL1_RST;
      ctrl2_ff  <= CTRL2_RST;
      trim_ff   <= TRIM_RST;
      status_ff <= STATUS_RST;
    end
    else if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        OFS_CTRL1:  ctrl1_ff  <= bus_i.wdata;
        OFS_CTRL2:  ctrl2_ff  <= bus_i.wdata;
        OFS_TRIM:   trim_ff   <= bus_i.wdata;
        OFS_STATUS: status_ff <= bus_i.wdata;
        default:    ;
      endcase
    end
  end

  wire logic [1:0] clk_src     = ctrl1_ff[CLK_SRC_LSB+:2];
  wire logic [2:0] ref_div_sel = ctrl1_ff[REF_DIV_LSB+:3];
  wire logic       int_ref_sel = ctrl1_ff[INT_REF_SEL_BIT];
  wire logic       low_power   = ctrl2_ff[LOW_POWER_BIT];
  wire logic       dco_max     = status_ff[DCO_MAX_BIT];

  logic [DATA_W-1:0] rd_val;
  logic [1:0]        clk_st;

  always_comb
  begin
    clk_st = CLK_SRC_LOOP;
    if (mode_ff == MODE_BYP_INT || mode_ff == MODE_BYP_INT_LP)
    begin
      clk_st = CLK_SRC_IREF;
    end
    else if (mode_ff == MODE_BYP_EXT || mode_ff == MODE_BYP_EXT_LP)
    begin
      clk_st = CLK_SRC_EREF;
    end
    rd_val = '0;
    unique case (bus_i.addr)
      OFS_CTRL1: rd_val = ctrl1_ff;
      OFS_CTRL2: rd_val = ctrl2_ff;
      OFS_TRIM:  rd_val = trim_ff;
      OFS_STATUS:
      begin
        rd_val[DCO_RANGE_LSB+:2] = DCO_RANGE_LOW;
        rd_val[DCO_MAX_BIT]      = dco_max;
        rd_val[INT_REF_ST_BIT]   = int_ref_sel;
        rd_val[CLK_ST_LSB+:2]    = clk_st;
        rd_val[LOCK_BIT]         = locked_ff;
        rd_val[FINE_TRIM_BIT]    = status_ff[FINE_TRIM_BIT];
      end
      default:   rd_val = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= bus_i.rd ? rd_val : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference synchronisers and edge detect
  logic [2:0] iref_sync_ff;
  logic [2:0] eref_sync_ff;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      iref_sync_ff <= '0;
      eref_sync_ff <= '0;
    end
    else
    begin
      iref_sync_ff <= {iref_sync_ff[1:0], int_ref_clk_i};
      eref_sync_ff <= {eref_sync_ff[1:0], ext_ref_clk_i};
    end
  end

  wire logic iref_tick = iref_sync_ff[1] & ~iref_sync_ff[2];
  wire logic eref_tick = eref_sync_ff[1] & ~eref_sync_ff[2];

  // external reference divider
  logic [10:0] ref_cnt_ff;
  logic        eref_div_tick;
  wire logic [10:0] ref_ratio = ref_div_ratio(ref_div_sel, ctrl2_ff[FREQ_RANGE_BIT]);

  assign eref_div_tick = eref_tick && (ref_cnt_ff >= ref_ratio - 11'h001);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_cnt_ff <= '0;
    end
    else if (eref_tick)
    begin
      ref_cnt_ff <= eref_div_tick ? 11'h000 : ref_cnt_ff + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode
  fcss_mode_t nxt_mode;

  always_comb
  begin
    nxt_mode = MODE_ENG_INT;
    if (stop_req_i)
    begin
      nxt_mode = MODE_STOP;
    end
    else if (clk_src == CLK_SRC_IREF)
    begin
      nxt_mode = (low_power && !debug_active_i) ? MODE_BYP_INT_LP : MODE_BYP_INT;
    end
    else if (clk_src == CLK_SRC_EREF)
    begin
      nxt_mode = (low_power && !debug_active_i) ? MODE_BYP_EXT_LP : MODE_BYP_EXT;
    end
    else
    begin
      nxt_mode = int_ref_sel ? MODE_ENG_INT : MODE_ENG_EXT;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_ff <= MODE_ENG_INT;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  wire logic loop_en = (mode_ff != MODE_STOP) && (mode_ff != MODE_BYP_INT_LP)
                       && (mode_ff != MODE_BYP_EXT_LP);

  ////////////////////////////////////////////////////////////////////////////////
  // frequency-locked loop
  logic [ACC_W-1:0]     acc_ff;
  logic [ACC_W-1:0]     fw_ff;
  logic [11:0]          dco_cnt_ff;
  logic [ACC_W:0]       acc_sum;
  logic                 dco_tick;
  logic                 loop_ref_tick;
  logic [11:0]          target;
  logic signed [12:0]   err;
  logic signed [SW-1:0] fw_sum;

  assign acc_sum       = {1'b0, acc_ff} + {1'b0, fw_ff};
  assign dco_tick      = loop_en & acc_sum[ACC_W];
  assign loop_ref_tick = int_ref_sel ? iref_tick : eref_div_tick;
  assign target        = dco_max ? FLL_FACTOR_MAX : FLL_FACTOR_STD;
  assign err           = $signed({1'b0, target}) - $signed({1'b0, dco_cnt_ff});
  assign fw_sum        = $signed({2'b00, fw_ff}) + (SW'(err) <<< GAIN_SH);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc_ff <= '0;
    end
    else
    begin
      acc_ff <= loop_en ? acc_sum[ACC_W-1:0] : '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fw_ff      <= FW_RST;
      dco_cnt_ff <= '0;
      locked_ff  <= 1'b0;
    end
    else if (!loop_en)
    begin
      dco_cnt_ff <= '0;
      locked_ff  <= 1'b0;
    end
    else if (loop_ref_tick)
    begin
      dco_cnt_ff <= {11'h000, dco_tick};
      locked_ff  <= (err >= -13'sd1) && (err <= 13'sd1);
      if (fw_sum < $signed(SW'(1)))
      begin
        fw_ff <= {{(ACC_W-1){1'b0}}, 1'b1};
      end
      else if (fw_sum > $signed({2'b00, FW_MAX}))
      begin
        fw_ff <= FW_MAX;
      end
      else
      begin
        fw_ff <= fw_sum[ACC_W-1:0];
      end
    end
    else if (dco_tick && dco_cnt_ff != 12'hfff)
    begin
      dco_cnt_ff <= dco_cnt_ff + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source select and bus divider
  logic       src_tick;
  logic [3:0] div_cnt_ff;
  wire logic [3:0] div_ratio = bus_div_ratio(ctrl2_ff[BUS_DIV_LSB+:2]);
  wire logic       div_hit   = src_tick && (div_cnt_ff >= div_ratio - 4'h1);

  always_comb
  begin
    unique case (mode_ff)
      MODE_ENG_INT, MODE_ENG_EXT:       src_tick = dco_tick;
      MODE_BYP_INT, MODE_BYP_INT_LP:    src_tick = iref_tick;
      MODE_BYP_EXT, MODE_BYP_EXT_LP:    src_tick = eref_tick;
      default:                          src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_cnt_ff <= '0;
      bus_tick_o <= 1'b0;
    end
    else
    begin
      bus_tick_o <= div_hit;
      if (src_tick)
      begin
        div_cnt_ff <= div_hit ? 4'h0 : div_cnt_ff + 4'h1;
      end
    end
  end

  // debug clock toggles per oscillator tick, held low while the loop is off
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      debug_clk_o <= 1'b0;
    end
    else if (!loop_en)
    begin
      debug_clk_o <= 1'b0;
    end
    else if (dco_tick)
    begin
      debug_clk_o <= ~debug_clk_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference enables, trim and oscillator control
  wire logic in_stop  = (mode_ff == MODE_STOP);
  wire logic iref_use = int_ref_sel | (clk_src == CLK_SRC_IREF) | ctrl1_ff[INT_CLK_EN_BIT];
  wire logic eref_use = ~int_ref_sel | (clk_src == CLK_SRC_EREF) | ctrl2_ff[EXT_CLK_EN_BIT];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      int_ref_enable_o <= 1'b1;
      int_trim_o       <= '0;
      osc_ctrl_o       <= '0;
      fll_locked_o     <= 1'b0;
      mode_o           <= MODE_ENG_INT;
    end
    else
    begin
      int_ref_enable_o <= in_stop ? (ctrl1_ff[INT_CLK_EN_BIT] & ctrl1_ff[INT_STOP_EN_BIT])
                                  : iref_use;
      int_trim_o       <= {trim_ff, status_ff[FINE_TRIM_BIT]};
      osc_ctrl_o.high_gain_select     <= ctrl2_ff[HIGH_GAIN_BIT];
      osc_ctrl_o.freq_range           <= ctrl2_ff[FREQ_RANGE_BIT];
      osc_ctrl_o.ext_ref_osc_select   <= ctrl2_ff[EXT_OSC_SEL_BIT];
      osc_ctrl_o.ext_ref_clock_enable <= in_stop ? (ctrl2_ff[EXT_CLK_EN_BIT]
                                                    & ctrl2_ff[EXT_STOP_EN_BIT])
                                                 : eref_use;
      osc_ctrl_o.ext_ref_stop_enable  <= ctrl2_ff[EXT_STOP_EN_BIT];
      fll_locked_o     <= locked_ff;
      mode_o           <= mode_ff;
    end
  end

endmodule

//--- tb/fcss_top_sva.sv
`timescale 1ns/1ps
module fcss_top_sva
  import fcss_pkg::*;
(
  // clock and reset
  input wire logic           clk_i,
  input wire logic           rstn_i,
  // observed outputs
  input wire logic           bus_tick_o,
  input wire logic           debug_clk_o,
  input wire fcss_mode_t     mode_o,
  input wire logic           int_ref_enable_o,
  input wire logic [8:0]     int_trim_o,
  input wire fcss_osc_ctrl_t osc_ctrl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////////////
  property p_stop_quiet;
    mode_o == MODE_STOP && $past(mode_o) == MODE_STOP |-> !bus_tick_o && !debug_clk_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("clock activity in stop");

  property p_lp_no_dbg;
    mode_o inside {MODE_BYP_INT_LP, MODE_BYP_EXT_LP} && $stable(mode_o) |-> !debug_clk_o;
  endproperty
  a_lp_no_dbg: assert property (p_lp_no_dbg)
    else $error("debug clock in low power bypass");

  property p_rst_mode;
    rstn_i && !$past(rstn_i) |-> mode_o == MODE_ENG_INT && int_ref_enable_o;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("wrong mode after reset");

  property p_trim_rst;
    $past(rstn_i) && !$past(rstn_i, 2) |-> int_trim_o == 9'h100;
  endproperty
  a_trim_rst: assert property (p_trim_rst)
    else $error("trim not at reset value");

  // reference enables follow the control registers one stage ahead of mode_o
  property p_engint_iref;
    mode_o == MODE_ENG_INT && $past(mode_o) == MODE_ENG_INT |-> $past(int_ref_enable_o);
  endproperty
  a_engint_iref: assert property (p_engint_iref)
    else $error("internal reference off in engaged internal");

  property p_engext_eref;
    (mode_o == MODE_ENG_EXT) [*2] |-> $past(osc_ctrl_o.ext_ref_clock_enable);
  endproperty
  a_engext_eref: assert property (p_engext_eref)
    else $error("external reference off in engaged external");

  property p_bypint_iref;
    mode_o inside {MODE_BYP_INT, MODE_BYP_INT_LP} && $stable(mode_o) |-> $past(int_ref_enable_o);
  endproperty
  a_bypint_iref: assert property (p_bypint_iref)
    else $error("internal reference off while selected");

  property p_bypext_eref;
    mode_o inside {MODE_BYP_EXT, MODE_BYP_EXT_LP} && $stable(mode_o)
      |-> $past(osc_ctrl_o.ext_ref_clock_enable);
  endproperty
  a_bypext_eref: assert property (p_bypext_eref)
    else $error("external reference off while selected");
endmodule

bind fcss_top fcss_top_sva u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .bus_tick_o(bus_tick_o), .debug_clk_o(debug_clk_o),
  .mode_o(mode_o), .int_ref_enable_o(int_ref_enable_o), .int_trim_o(int_trim_o),
  .osc_ctrl_o(osc_ctrl_o)
);

//--- tb/fcss_ref_model.sv
`timescale 1ns/1ps
module fcss_ref_model #(
  parameter int unsigned INT_HALF_NS = 40000,
  parameter int unsigned EXT_HALF_NS = 5000
) (
  // oscillator control
  input  wire logic ext_en_i,
  // reference clocks
  output logic      int_ref_clk_o,
  output logic      ext_ref_clk_o
);
  // internal reference runs free, phase unrelated to the system clock
  initial
  begin
    int_ref_clk_o = 1'b0;
    #13;
    forever #(INT_HALF_NS) int_ref_clk_o = ~int_ref_clk_o;
  end

  // crystal output stands low while its enable is off
  initial
  begin
    ext_ref_clk_o = 1'b0;
    #29;
    forever #(EXT_HALF_NS) ext_ref_clk_o = ext_en_i ? ~ext_ref_clk_o : 1'b0;
  end
endmodule

//--- tb/tb_fcss_top.sv
`timescale 1ns/1ps
module tb_fcss_top;
  import fcss_pkg::*;
  logic           clk_i;
  logic           rstn_i;
  fcss_bus_req_t  bus;
  logic [7:0]     rdata;
  logic           iref;
  logic           eref;
  logic           stop;
  logic           dbg;
  logic           tick;
  logic           dclk;
  logic           lock;
  fcss_mode_t     mode;
  logic           iren;
  logic [8:0]     trim;
  fcss_osc_ctrl_t osc;
  int             n_mismatch;
  int             checked;
  int             cnt;
  int             dcnt;
  logic [7:0]     d;
  logic [7:0]     w;
  logic           f;
  logic [20:0]    tbl [8];

  // internal reference period of the partner model in system clocks
  localparam int  IREF_CYC = 800;

  fcss_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata), .int_ref_clk_i(iref),
    .ext_ref_clk_i(eref), .stop_req_i(stop), .debug_active_i(dbg), .bus_tick_o(tick),
    .debug_clk_o(dclk), .fll_locked_o(lock), .mode_o(mode), .int_ref_enable_o(iren),
    .int_trim_o(trim), .osc_ctrl_o(osc)
  );
  fcss_ref_model ref_m (.ext_en_i(osc.ext_ref_clock_enable), .int_ref_clk_o(iref),
    .ext_ref_clk_o(eref));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clk_i);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    bus <= '0;
    @(negedge clk_i);
    v = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic near(input string s, input int e, input int g);
    checked++;
    if (g < e - 4 || g > e + 4)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %0d got %0d", s, e, g);
    end
  endtask

  function automatic int exp_ticks(input int fac, input int n, input int k);
    return (fac * n) >> k;
  endfunction

  // bus ticks and debug clock rises seen over n internal reference periods
  task automatic count(input int n, output int c, output int dc);
    logic p;
    c = 0;
    dc = 0;
    @(posedge iref);
    p = dclk;
    repeat (n * IREF_CYC)
    begin
      @(posedge clk_i);
      c += int'(tick === 1'b1);
      dc += int'(dclk === 1'b1 && p === 1'b0);
      p = dclk;
    end
  endtask

  task automatic wait_lock();
    repeat (1700) @(posedge clk_i);
    for (int i = 0; i < 300 && lock !== 1'b1; i++)
      repeat (100) @(posedge clk_i);
    chk("locked", 12'h001, {11'h0, lock});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #9_000_000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    rstn_i = 1'b0;
    bus = '0;
    stop = 1'b0;
    dbg = 1'b0;
    n_mismatch = 0;
    checked = 0;
    tbl = '{{8'h04, 8'h00, 2'b00, 3'(MODE_ENG_INT)}, {8'h18, 8'h00, 2'b00, 3'(MODE_ENG_EXT)},
            {8'h44, 8'h00, 2'b00, 3'(MODE_BYP_INT)}, {8'h44, 8'h08, 2'b00, 3'(MODE_BYP_INT_LP)},
            {8'h44, 8'h08, 2'b01, 3'(MODE_BYP_INT)}, {8'h98, 8'h00, 2'b00, 3'(MODE_BYP_EXT)},
            {8'h98, 8'h08, 2'b00, 3'(MODE_BYP_EXT_LP)}, {8'h04, 8'h00, 2'b10, 3'(MODE_STOP)}};
    void'($urandom(32'h1f9d981a));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle(1);
    chk("mode", 12'(MODE_ENG_INT), 12'(mode));
    rd(OFS_CTRL1, d);
    chk("ctrl1", 12'h004, 12'(d));
    rd(OFS_CTRL2, d);
    chk("ctrl2", 12'h040, 12'(d));
    rd(OFS_STATUS, d);
    chk("status", 12'h010, 12'(d & 8'hfd));
    $display("test reset done");
    w = 8'($urandom);
    f = 1'($urandom);
    wr(OFS_TRIM, w);
    wr(OFS_STATUS, {2'($urandom_range(3, 1)), 5'h00, f});
    settle(1);
    chk("trim out", {3'h0, w, f}, {3'h0, trim});
    rd(OFS_STATUS, d);
    chk("status", {4'h0, 7'h08, f}, 12'(d & 8'hfd));
    w = 8'($urandom);
    wr(OFS_CTRL2, {2'h0, w[5:4], 1'b0, w[2:0]});
    settle(1);
    chk("osc", {7'h0, w[4], w[5], w[2:0]}, {7'h0, osc});
    wr(3'h5, 8'hff);
    rd(3'h5, d);
    chk("unmapped", 12'h000, 12'(d));
    $display("test registers done");
    wr(OFS_CTRL2, 8'h00);
    wait_lock();
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_CTRL2, 8'(k << 6));
      count(2, cnt, dcnt);
      near("bus ticks", exp_ticks(512, 2, k), cnt);
      near("debug clock", exp_ticks(512, 2, 1), dcnt);
    end
    wr(OFS_CTRL2, 8'h00);
    wr(OFS_STATUS, 8'h20);
    wait_lock();
    count(2, cnt, dcnt);
    near("max ticks", exp_ticks(608, 2, 0), cnt);
    near("max debug clock", exp_ticks(608, 2, 1), dcnt);
    $display("test loop done");
    foreach (tbl[i])
    begin
      wr(OFS_CTRL1, tbl[i][20:13]);
      wr(OFS_CTRL2, tbl[i][12:5]);
      @(posedge clk_i);
      stop <= tbl[i][4];
      dbg <= tbl[i][3];
      settle(3);
      chk("mode", 12'(tbl[i][2:0]), 12'(mode));
      settle(20);
    end
    $display("test modes done");
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    rstn_i <= 1'b1;
    stop <= 1'b0;
    settle(1);
    chk("mode", 12'(MODE_ENG_INT), 12'(mode));
    $display("test rereset done");
    final_report();
  end
endmodule
